/* File: flag_pkg.sv */
/*
 * Shared constants for the packet status flag bank: register offsets,
 * bit positions, reset values and the byte buffer depth.
 * Assumes an 8-bit register port and one 100 MHz clock.
 */
package flag_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_LOWBAT = 8'h3d;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS1 = 8'h3e;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS2 = 8'h3f;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h61;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h62;

    ////////////////////////////////////////////////////////////////////////
    // first flag register
    localparam int F1_TIMEOUT = 2;
    localparam int F1_PREAMBLE = 1;
    localparam int F1_SYNC = 0;

    // second flag register
    localparam int F2_FULL = 7;
    localparam int F2_EMPTY = 6;
    localparam int F2_LEVEL = 5;
    localparam int F2_OVERRUN = 4;
    localparam int F2_SENT = 3;
    localparam int F2_RECEIVED = 2;
    localparam int F2_CHECKSUM = 1;
    localparam int F2_SUPPLY = 0;

    // supply monitor register
    localparam int LB_ENABLE = 3;
    localparam int LB_TRIM_W = 3;
    localparam logic LB_ENABLE_RESET = 1'b0;
    localparam logic [LB_TRIM_W-1:0] LB_TRIM_RESET = 3'h2;

    // level limit register: limit in low bits, keep-on-fail in bit 7
    localparam int LIMIT_W = 6;
    localparam int LIMIT_KEEP = 7;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 6'h0f;
    localparam logic KEEP_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask layout
    localparam int IRQ_SUPPLY = 0;
    localparam int IRQ_CHECKSUM = 1;
    localparam int IRQ_RECEIVED = 2;
    localparam int IRQ_SENT = 3;
    localparam int IRQ_OVERRUN = 4;
    localparam int IRQ_TIMEOUT = 5;
    localparam int IRQ_PREAMBLE = 6;
    localparam int IRQ_SYNC = 7;
    localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // byte buffer
    localparam int FIFO_DEPTH = 66;
    localparam int COUNT_W = $clog2(FIFO_DEPTH + 1);

endpackage

/* File: fifo_level_if.sv */
/*
 * Carrier between the flag bank and its byte occupancy counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface fifo_level_if #(parameter int COUNT_W = 7);
    logic push;
    logic pop;
    logic flush;
    logic overrunEv;
    logic [COUNT_W-1:0] count;

    modport bank (output push, output pop, output flush, input overrunEv, input count);
    modport counter (input push, input pop, input flush, output overrunEv, output count);
endinterface

`default_nettype wire

/* File: sticky_flag.sv */
/*
 * Vector of sticky flags: set pulses win over clear pulses.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module sticky_flag #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // state
    output logic [W-1:0] q
);

    // set dominates so an event in the clearing cycle is kept
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= set | (q & ~clr);
        end
    end

endmodule

`default_nettype wire

/* File: fifo_level_counter.sv */
/*
 * Occupancy counter for the packet byte buffer; reports overrun.
 * Assumes push and pop strobes are one cycle each from the datapath.
 */
`timescale 1ns/100ps
`default_nettype none

module fifo_level_counter #(
    parameter int DEPTH = 66,
    parameter int COUNT_W = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link to the flag bank
    fifo_level_if.counter lvl
);

    logic full;
    logic empty;
    logic pushOk;
    logic popOk;

    assign full = (lvl.count == COUNT_W'(DEPTH));
    assign empty = (lvl.count == '0);
    // a push into a full buffer pushes nothing and is an overrun unless a pop comes in the same cycle
    assign pushOk = lvl.push && !full;
    assign popOk = lvl.pop && !empty;
    assign lvl.overrunEv = lvl.push && full && !lvl.pop;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl.count <= '0;
        end else if (lvl.flush) begin
            lvl.count <= '0;
        end else if (pushOk && !popOk) begin
            lvl.count <= lvl.count + COUNT_W'(1);
        end else if (popOk && !pushOk) begin
            lvl.count <= lvl.count - COUNT_W'(1);
        end
    end

endmodule

`default_nettype wire

/* File: packet_irq_status_flags.sv */
/*
 * Packet engine status flags, supply monitor flag, and interrupt bank.
 * Assumes datapath strobes are on mclk; the comparator pin is asynchronous.
 */
// Notes on behaviour
// - timeout flag sets on timeout, clears leaving receive or when the buffer becomes empty
// - preamble flag sets on valid preamble, cleared by writing one
// - sync flag sets on sync and address match, clears leaving receive or when the buffer becomes empty
// - sync flag read-only in packet mode, write-one clear in continuous mode
// - full flag high exactly while the buffer holds 66 bytes
// - empty flag high while no bytes, low with one or more
// - level flag high only while count strictly exceeds the limit
// - overrun flag sets on buffer overrun outside sleep
// - writing one to overrun clears flags and flushes the buffer one cycle later
// - sent flag sets in transmit after whole packet, clears leaving transmit
// - received flag after last byte, checksum gating unless keep bit set
// - checksum flag sets on good payload checksum, clears when empty
// - supply flag sets on low battery, only write-one clears it
// - supply comparison only while monitor enable is one, reset zero
`timescale 1ns/100ps
`default_nettype none

module packet_irq_status_flags (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [flag_pkg::ADDR_W-1:0] regAddr,
    input wire logic [flag_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [flag_pkg::DATA_W-1:0] regRdata,
    // operating mode from the main sequencer
    input wire logic rxMode,
    input wire logic txMode,
    input wire logic sleepMode,
    input wire logic packetMode,
    input wire logic crcOn,
    // datapath events
    input wire logic fifoPush,
    input wire logic fifoPop,
    input wire logic rxTimeout,
    input wire logic preambleSeen,
    input wire logic syncSeen,
    input wire logic frameDone,
    input wire logic lastByteIn,
    input wire logic crcPass,
    // supply comparator
    input wire logic supplyLowPin,
    output logic [flag_pkg::LB_TRIM_W-1:0] supplyTrim,
    // buffer control and interrupt
    output logic fifoFlush,
    output logic [flag_pkg::COUNT_W-1:0] fifoCount,
    output logic irq
);
    import flag_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic monitorEnable_r;
    logic [LB_TRIM_W-1:0] trim_r;
    logic [LIMIT_W-1:0] limit_r;
    logic keep_r;
    logic [DATA_W-1:0] irqMask_r;
    logic flush_r;

    logic wrLowbat;
    logic wrFlags1;
    logic wrFlags2;
    logic wrLimit;
    logic wrStatus;
    logic wrMask;

    assign wrLowbat = regWr && (regAddr == ADDR_LOWBAT);
    assign wrFlags1 = regWr && (regAddr == ADDR_FLAGS1);
    assign wrFlags2 = regWr && (regAddr == ADDR_FLAGS2);
    assign wrLimit = regWr && (regAddr == ADDR_LIMIT);
    assign wrStatus = regWr && (regAddr == ADDR_IRQ_STATUS);
    assign wrMask = regWr && (regAddr == ADDR_IRQ_MASK);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            monitorEnable_r <= LB_ENABLE_RESET;
            trim_r <= LB_TRIM_RESET;
        end else if (wrLowbat) begin
            monitorEnable_r <= regWdata[LB_ENABLE];
            trim_r <= regWdata[LB_TRIM_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            limit_r <= LIMIT_RESET;
            keep_r <= KEEP_RESET;
        end else if (wrLimit) begin
            limit_r <= regWdata[LIMIT_W-1:0];
            keep_r <= regWdata[LIMIT_KEEP];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqMask_r <= IRQ_MASK_RESET;
        end else if (wrMask) begin
            irqMask_r <= regWdata;
        end
    end

    assign supplyTrim = trim_r;

    ////////////////////////////////////////////////////////////////////////
    // byte occupancy

    logic overrunClr;
    logic buffer_full_flag;
    logic buffer_empty_flag;
    logic buffer_level_flag;

    fifo_level_if #(.COUNT_W(COUNT_W)) lvl ();

    // flush pulse one cycle after the write; the count is zero the cycle after
    assign overrunClr = wrFlags2 && regWdata[F2_OVERRUN];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flush_r <= 1'b0;
        end else begin
            flush_r <= overrunClr;
        end
    end

    assign lvl.push = fifoPush;
    assign lvl.pop = fifoPop;
    assign lvl.flush = flush_r;
    assign fifoFlush = flush_r;
    assign fifoCount = lvl.count;

    fifo_level_counter #(
        .DEPTH(FIFO_DEPTH),
        .COUNT_W(COUNT_W)
    ) counter (
        .mclk(mclk),
        .rst(rst),
        .lvl(lvl)
    );

    assign buffer_full_flag = (lvl.count == COUNT_W'(FIFO_DEPTH));
    assign buffer_empty_flag = (lvl.count == '0);
    assign buffer_level_flag = (lvl.count > COUNT_W'(limit_r));

    ////////////////////////////////////////////////////////////////////////
    // supply comparator synchroniser

    logic supplySync1_r;
    logic supplySync2_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            supplySync1_r <= 1'b0;
            supplySync2_r <= 1'b0;
        end else begin
            supplySync1_r <= supplyLowPin;
            supplySync2_r <= supplySync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode edges

    logic rxMode_r;
    logic txMode_r;
    logic leaveRx;
    logic leaveTx;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxMode_r <= 1'b0;
            txMode_r <= 1'b0;
        end else begin
            rxMode_r <= rxMode;
            txMode_r <= txMode;
        end
    end

    assign leaveRx = rxMode_r && !rxMode;
    assign leaveTx = txMode_r && !txMode;

    // buffer becoming empty is an event: a level clear would wipe a
    // timeout or sync taken while the buffer is still empty
    logic fifoEmptyPrev_r;
    logic emptyRise;

    // resets to one since the buffer is empty after reset: no false edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fifoEmptyPrev_r <= 1'b1;
        end else begin
            fifoEmptyPrev_r <= buffer_empty_flag;
        end
    end

    assign emptyRise = buffer_empty_flag && !fifoEmptyPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // status flags, one sticky bit each

    logic [7:0] flagSet;
    logic [7:0] flagClr;
    logic [7:0] flagQ;
    logic frameGood;

    // with checksum on, a bad frame is only announced if software keeps it
    assign frameGood = !crcOn || keep_r || crcPass;

    always_comb begin
        flagSet = '0;
        flagClr = '0;
        flagSet[IRQ_TIMEOUT] = rxMode && rxTimeout;
        flagClr[IRQ_TIMEOUT] = leaveRx || emptyRise;
        flagSet[IRQ_PREAMBLE] = preambleSeen;
        flagClr[IRQ_PREAMBLE] = wrFlags1 && regWdata[F1_PREAMBLE];
        flagSet[IRQ_SYNC] = rxMode && syncSeen;
        // packet mode ignores the write, continuous mode clears on one
        flagClr[IRQ_SYNC] = leaveRx || emptyRise
            || (wrFlags1 && regWdata[F1_SYNC] && !packetMode);
        flagSet[IRQ_OVERRUN] = lvl.overrunEv && !sleepMode;
        flagClr[IRQ_OVERRUN] = overrunClr;
        flagSet[IRQ_SENT] = txMode && frameDone;
        flagClr[IRQ_SENT] = leaveTx || overrunClr;
        flagSet[IRQ_RECEIVED] = rxMode && lastByteIn && frameGood;
        flagClr[IRQ_RECEIVED] = buffer_empty_flag || overrunClr;
        flagSet[IRQ_CHECKSUM] = rxMode && lastByteIn && crcOn && crcPass;
        flagClr[IRQ_CHECKSUM] = buffer_empty_flag || overrunClr;
        flagSet[IRQ_SUPPLY] = monitorEnable_r && supplySync2_r;
        flagClr[IRQ_SUPPLY] = wrFlags2 && regWdata[F2_SUPPLY];
    end

    sticky_flag #(.W(8)) flags (
        .mclk(mclk),
        .rst(rst),
        .set(flagSet),
        .clr(flagClr),
        .q(flagQ)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: rising flags latch here until written with one

    logic [7:0] flagPrev_r;
    logic [7:0] irqStatus;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flagPrev_r <= '0;
        end else begin
            flagPrev_r <= flagQ;
        end
    end

    sticky_flag #(.W(8)) status (
        .mclk(mclk),
        .rst(rst),
        .set(flagQ & ~flagPrev_r),
        .clr(wrStatus ? regWdata : 8'h00),
        .q(irqStatus)
    );

    assign irq = |(irqStatus & irqMask_r);

    ////////////////////////////////////////////////////////////////////////
    // read path, data valid the cycle after the strobe

    logic [DATA_W-1:0] flags1;
    logic [DATA_W-1:0] flags2;
    logic [DATA_W-1:0] rdMux;

    always_comb begin
        flags1 = '0;
        flags1[F1_TIMEOUT] = flagQ[IRQ_TIMEOUT];
        flags1[F1_PREAMBLE] = flagQ[IRQ_PREAMBLE];
        flags1[F1_SYNC] = flagQ[IRQ_SYNC];
    end

    always_comb begin
        flags2 = '0;
        flags2[F2_FULL] = buffer_full_flag;
        flags2[F2_EMPTY] = buffer_empty_flag;
        flags2[F2_LEVEL] = buffer_level_flag;
        flags2[F2_OVERRUN] = flagQ[IRQ_OVERRUN];
        flags2[F2_SENT] = flagQ[IRQ_SENT];
        flags2[F2_RECEIVED] = flagQ[IRQ_RECEIVED];
        flags2[F2_CHECKSUM] = flagQ[IRQ_CHECKSUM];
        flags2[F2_SUPPLY] = flagQ[IRQ_SUPPLY];
    end

    always_comb begin
        rdMux = '0;
        case (regAddr)
            ADDR_LOWBAT: begin
                rdMux[LB_ENABLE] = monitorEnable_r;
                rdMux[LB_TRIM_W-1:0] = trim_r;
            end
            ADDR_FLAGS1: rdMux = flags1;
            ADDR_FLAGS2: rdMux = flags2;
            ADDR_LIMIT: begin
                rdMux[LIMIT_W-1:0] = limit_r;
                rdMux[LIMIT_KEEP] = keep_r;
            end
            ADDR_IRQ_STATUS: rdMux = irqStatus;
            ADDR_IRQ_MASK: rdMux = irqMask_r;
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            regRdata <= rdMux;
        end else begin
            regRdata <= '0;
        end
    end

endmodule

`default_nettype wire

/* File: packet_flags_checker.sv */
/*
 * Port-level assertions for the packet status flag bank.
 * Assumes one clock and the asynchronous active-high reset of the top.
 */
`timescale 1ns/100ps
`default_nettype none

module packet_flags_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [flag_pkg::ADDR_W-1:0] regAddr,
    input wire logic [flag_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [flag_pkg::DATA_W-1:0] regRdata,
    // buffer side
    input wire logic fifoPush,
    input wire logic fifoPop,
    input wire logic [flag_pkg::LB_TRIM_W-1:0] supplyTrim,
    input wire logic fifoFlush,
    input wire logic [flag_pkg::COUNT_W-1:0] fifoCount
);
    import flag_pkg::*;

    logic [LB_TRIM_W-1:0] wTrim;
    logic ovrClr;
    logic rdF2;
    assign wTrim = regWdata[LB_TRIM_W-1:0];
    assign ovrClr = regWr && regAddr == ADDR_FLAGS2 && regWdata[F2_OVERRUN];
    assign rdF2 = regRd && regAddr == ADDR_FLAGS2;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    property p_flush; ovrClr |=> fifoFlush ##1 (fifoCount == '0); endproperty
    a_flush: assert property (p_flush) else $error("no flush after overrun clear");
    property p_flush_cause; fifoFlush |-> $past(ovrClr); endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("stray flush");
    property p_count_max; fifoCount <= FIFO_DEPTH; endproperty
    a_count_max: assert property (p_count_max) else $error("count above depth");
    // flush cycles excluded: the counter zeroes on the following edge
    property p_push;
        fifoPush && !fifoPop && !fifoFlush && fifoCount < FIFO_DEPTH
            |=> fifoCount == $past(fifoCount) + 1'b1;
    endproperty
    a_push: assert property (p_push) else $error("push not counted");
    property p_pop;
        fifoPop && !fifoPush && !fifoFlush && fifoCount > 0
            |=> fifoCount == $past(fifoCount) - 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop not counted");
    property p_drop;
        fifoPush && !fifoPop && !fifoFlush && fifoCount == FIFO_DEPTH |=> fifoCount == FIFO_DEPTH;
    endproperty
    a_drop: assert property (p_drop) else $error("push into full buffer kept");
    property p_empty_bit; rdF2 |=> regRdata[F2_EMPTY] == ($past(fifoCount) == '0); endproperty
    a_empty_bit: assert property (p_empty_bit) else $error("empty bit wrong");
    property p_full_bit; rdF2 |=> regRdata[F2_FULL] == ($past(fifoCount) == FIFO_DEPTH); endproperty
    a_full_bit: assert property (p_full_bit) else $error("full bit wrong");
    property p_trim; regWr && regAddr == ADDR_LOWBAT |=> supplyTrim == $past(wTrim); endproperty
    a_trim: assert property (p_trim) else $error("trim not taken");
endmodule

bind packet_irq_status_flags packet_flags_checker chk_u (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .fifoPush(fifoPush), .fifoPop(fifoPop),
    .supplyTrim(supplyTrim), .fifoFlush(fifoFlush), .fifoCount(fifoCount));

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the packet status flag bank.
 * Assumes the bench alone drives the register port and datapath strobes.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, a, b); end end

module tb;
    import flag_pkg::*;

    localparam int PUSH = 0, POP = 1, TMO = 2, PRE = 3, SYN = 4, DONE = 5, LAST = 6;
    logic mclk, rst, regWr, regRd, rxMode, txMode, sleepMode, packetMode, crcOn;
    logic crcPass, supplyLowPin, fifoFlush, irq;
    logic [6:0] ev;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata;
    logic [LB_TRIM_W-1:0] supplyTrim;
    logic [COUNT_W-1:0] fifoCount;
    int fail_count = 0, n_checks = 0, cycles = 0;

    packet_irq_status_flags dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rxMode(rxMode), .txMode(txMode), .sleepMode(sleepMode), .packetMode(packetMode),
        .crcOn(crcOn), .fifoPush(ev[PUSH]), .fifoPop(ev[POP]), .rxTimeout(ev[TMO]),
        .preambleSeen(ev[PRE]), .syncSeen(ev[SYN]), .frameDone(ev[DONE]),
        .lastByteIn(ev[LAST]), .crcPass(crcPass), .supplyLowPin(supplyLowPin),
        .supplyTrim(supplyTrim), .fifoFlush(fifoFlush), .fifoCount(fifoCount), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask

    // strobe held for n back-to-back cycles
    task automatic burst(input int i, input int n);
        @(posedge mclk);
        ev[i] <= 1'b1;
        repeat (n) @(posedge mclk);
        ev[i] <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {regWr, regRd, rxMode, txMode, sleepMode, packetMode, crcOn} = '0;
        {crcPass, supplyLowPin} = '0;
        ev = '0;
        regAddr = '0;
        regWdata = '0;
        idle(4);
        rst <= 1'b0;
        rdchk(ADDR_LOWBAT, 8'h02);
        rdchk(ADDR_LIMIT, 8'h0f);
        rdchk(ADDR_FLAGS2, 8'h40);
        rdchk(8'h00, 8'h00);
        // preamble event through status, mask and irq
        wr(ADDR_IRQ_MASK, 8'h40);
        burst(PRE, 1);
        idle(3);
        #1 `CHK(irq, 1'b1)
        rdchk(ADDR_IRQ_STATUS, 8'h40);
        wr(ADDR_IRQ_MASK, 8'h00);
        #1 `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 8'h40);
        #1 `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STATUS, 8'h40);
        #1 `CHK(irq, 1'b0)
        wr(ADDR_FLAGS1, 8'h00);
        rdchk(ADDR_FLAGS1, 8'h02);
        wr(ADDR_FLAGS1, 8'h02);
        rdchk(ADDR_FLAGS1, 8'h00);
        // timeout and sync flags in receive
        @(posedge mclk) rxMode <= 1'b1;
        @(posedge mclk) packetMode <= 1'b1;
        burst(TMO, 1);
        burst(SYN, 1);
        rdchk(ADDR_FLAGS1, 8'h05);
        wr(ADDR_FLAGS1, 8'h05);
        rdchk(ADDR_FLAGS1, 8'h05);
        @(posedge mclk) packetMode <= 1'b0;
        wr(ADDR_FLAGS1, 8'h01);
        rdchk(ADDR_FLAGS1, 8'h04);
        @(posedge mclk) rxMode <= 1'b0;
        idle(2);
        rdchk(ADDR_FLAGS1, 8'h00);
        // level limit boundary, full, overrun
        burst(PUSH, 15);
        rdchk(ADDR_FLAGS2, 8'h00);
        burst(PUSH, 1);
        rdchk(ADDR_FLAGS2, 8'h20);
        burst(PUSH, 51);
        idle(2);
        rdchk(ADDR_FLAGS2, 8'hb0);
        `CHK(fifoCount, COUNT_W'(FIFO_DEPTH))
        wr(ADDR_FLAGS2, 8'h10);
        idle(2);
        rdchk(ADDR_FLAGS2, 8'h40);
        burst(PUSH, 1);
        rdchk(ADDR_FLAGS2, 8'h00);
        // an overrun while asleep leaves the flag alone
        @(posedge mclk) sleepMode <= 1'b1;
        burst(PUSH, 66);
        idle(2);
        rdchk(ADDR_FLAGS2, 8'ha0);
        @(posedge mclk) sleepMode <= 1'b0;
        burst(POP, 66);
        rdchk(ADDR_FLAGS2, 8'h40);
        // transmit done
        @(posedge mclk) txMode <= 1'b1;
        burst(DONE, 1);
        rdchk(ADDR_FLAGS2, 8'h48);
        @(posedge mclk) txMode <= 1'b0;
        idle(1);
        rdchk(ADDR_FLAGS2, 8'h40);
        // payload gated by the checksum
        @(posedge mclk) rxMode <= 1'b1;
        @(posedge mclk) crcOn <= 1'b1;
        burst(PUSH, 1);
        burst(LAST, 1);
        rdchk(ADDR_FLAGS2, 8'h00);
        @(posedge mclk) crcPass <= 1'b1;
        burst(LAST, 1);
        rdchk(ADDR_FLAGS2, 8'h06);
        burst(POP, 1);
        idle(1);
        rdchk(ADDR_FLAGS2, 8'h40);
        // keep-on-fail announces a bad frame; timeout clears when buffer empties
        wr(ADDR_LIMIT, 8'h8f);
        rdchk(ADDR_LIMIT, 8'h8f);
        @(posedge mclk) crcPass <= 1'b0;
        burst(PUSH, 1);
        burst(TMO, 1);
        burst(LAST, 1);
        rdchk(ADDR_FLAGS2, 8'h04);
        rdchk(ADDR_FLAGS1, 8'h04);
        burst(POP, 1);
        idle(2);
        rdchk(ADDR_FLAGS1, 8'h00);
        rdchk(ADDR_FLAGS2, 8'h40);
        // supply monitor
        @(posedge mclk) supplyLowPin <= 1'b1;
        idle(5);
        rdchk(ADDR_FLAGS2, 8'h40);
        wr(ADDR_LOWBAT, 8'h0d);
        #1 `CHK(supplyTrim, 3'h5)
        idle(5);
        rdchk(ADDR_FLAGS2, 8'h41);
        @(posedge mclk) supplyLowPin <= 1'b0;
        wr(ADDR_FLAGS2, 8'h00);
        idle(4);
        rdchk(ADDR_FLAGS2, 8'h41);
        wr(ADDR_FLAGS2, 8'h01);
        rdchk(ADDR_FLAGS2, 8'h40);
        conclude();
    end
endmodule

`default_nettype wire
